// >>> rtl/ser0_port.sv
// serial port zero device end with register access and transmit fifo
`timescale 1ns/1ns
`default_nettype none
module ser0_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic core_clk,
   input wire logic rstn,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0] wp_r;
   logic [AW:0] rp_r;
   logic full;
   logic empty;
   assign empty = (wp_r == rp_r);
   assign full = (wp_r[AW-1:0] == rp_r[AW-1:0]) && (wp_r[AW] != rp_r[AW]);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem_r[rp_r[AW-1:0]];
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wp_r <= '0;
      end else if (in_valid && !full) begin
         wp_r <= wp_r + 1'b1;
      end
   end
   always_ff @(posedge core_clk) begin
      if (in_valid && !full) begin
         mem_r[wp_r[AW-1:0]] <= in_data;
      end
   end
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rp_r <= '0;
      end else if (out_ready && !empty) begin
         rp_r <= rp_r + 1'b1;
      end
   end
endmodule // ser0_fifo

////////////////////////////////////////////////////////////////////////////////
module ser0_port (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // special-function register access
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   output logic sfr_wr_ready,
   // bit time for the variable-rate modes
   input wire logic [15:0] var_bit_cycles,
   // link
   ser0_link_if.dev link
);
   import ser0_pkg::*;

   logic mode_hi_r, mode_lo_r, mpq_r, ren_r, tb8_r, rb8_r, ti_r, ri_r, fe_r;
   logic fvs_r, dbl_r;
   logic [7:0] rx_buf_r;
   mode_t mode;
   logic [15:0] period;
   logic ctrl_wr, buf_wr, pwr_wr;
   logic ti_set, ri_set, fe_set, rb8_set_val, rb8_set;
   logic [7:0] rx_load;
   logic fifo_valid, fifo_pop;
   logic [7:0] fifo_data;
   logic dat_s1_r, dat_s2_r, dat_prev_r;

   assign mode = mode_t'({mode_hi_r, mode_lo_r}); // see RQ1
   assign period = bit_cycles(mode, mpq_r, dbl_r, var_bit_cycles); // see RQ6
   assign ctrl_wr = sfr_wr && (sfr_addr == SERIAL_CTRL_ADDR);
   assign pwr_wr = sfr_wr && (sfr_addr == POWER_CTRL_ADDR);
   assign buf_wr = sfr_wr && (sfr_addr == SERIAL_BUFFER_ADDR) && sfr_wr_ready;

   ////////////////////////////////////////////////////////////////////////////////
   // registers; a hardware set wins over a software clear in the same cycle
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         {mode_hi_r, mode_lo_r, mpq_r, ren_r, tb8_r} <= SERIAL_CTRL_RESET[7:3];
         fe_r <= 1'b0;
      end else begin
         if (ctrl_wr) begin
            if (!fvs_r) begin
               mode_hi_r <= sfr_wdata[B_MODE_HI]; // see RQ2
            end
            mode_lo_r <= sfr_wdata[B_MODE_LO];
            mpq_r <= sfr_wdata[B_MPQ];
            ren_r <= sfr_wdata[B_REN];
            tb8_r <= sfr_wdata[B_TB8]; // see RQ8
         end
         if (fe_set) begin
            fe_r <= 1'b1; // see RQ3
         end else if (ctrl_wr && fvs_r) begin
            fe_r <= sfr_wdata[B_MODE_HI]; // see RQ2
         end
      end
   end
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         {rb8_r, ti_r, ri_r} <= SERIAL_CTRL_RESET[2:0];
      end else begin
         ti_r <= ti_set | (ctrl_wr ? sfr_wdata[B_TI] : ti_r); // see RQ10
         ri_r <= ri_set | (ctrl_wr ? sfr_wdata[B_RI] : ri_r); // see RQ11
         if (rb8_set) begin
            rb8_r <= rb8_set_val; // see RQ9
         end else if (ctrl_wr) begin
            rb8_r <= sfr_wdata[B_RB8];
         end
      end
   end
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         {dbl_r, fvs_r} <= POWER_CTRL_RESET[7:6];
      end else if (pwr_wr) begin
         dbl_r <= sfr_wdata[B_DOUBLE_RATE];
         fvs_r <= sfr_wdata[B_FRAME_VIEW];
      end
   end
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rx_buf_r <= 8'h00;
      end else if (ri_set) begin
         rx_buf_r <= rx_load;
      end
   end
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_rd) begin
         case (sfr_addr)
            SERIAL_CTRL_ADDR: sfr_rdata <= {fvs_r ? fe_r : mode_hi_r, mode_lo_r, mpq_r, ren_r,
                                            tb8_r, rb8_r, ti_r, ri_r}; // see RQ2
            SERIAL_BUFFER_ADDR: sfr_rdata <= rx_buf_r; // see RQ12
            POWER_CTRL_ADDR: sfr_rdata <= {dbl_r, fvs_r, 6'h00};
            default: sfr_rdata <= 8'h00;
         endcase
      end
   end

   // writes to the buffer queue up; the cpu stalls only when the queue is full
   ser0_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) tx_fifo (
      .core_clk(core_clk),
      .rstn(rstn),
      .in_valid(buf_wr), // see RQ12
      .in_ready(sfr_wr_ready),
      .in_data(sfr_wdata),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // data line synchroniser; the second stage and its delayed copy are looked at
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         dat_s1_r <= 1'b1;
         dat_s2_r <= 1'b1;
         dat_prev_r <= 1'b1;
      end else begin
         dat_s1_r <= link.dat_line;
         dat_s2_r <= dat_s1_r;
         dat_prev_r <= dat_s2_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // transmit engine, also runs the mode 0 shift clock in both directions
   tx_state_t tx_st_r;
   logic [10:0] tx_sh_r;
   logic [3:0] tx_left_r;
   logic [15:0] tx_tmr_r;
   logic m0_rx_r, txd_r;
   logic m0_rx_start, tx_end_bit, m0_done;
   assign m0_rx_start = (mode == MODE_SHIFT) && ren_r && !ri_r && !fifo_valid; // see RQ7
   assign fifo_pop = (tx_st_r == TX_IDLE) && fifo_valid; // see RQ13
   assign tx_end_bit = (tx_st_r == TX_RUN) && (tx_tmr_r == 16'h0000);
   assign m0_done = tx_end_bit && (mode == MODE_SHIFT) && (tx_left_r == 4'h1);
   assign ti_set = tx_end_bit && !m0_rx_r &&
                   (tx_left_r == ((mode == MODE_SHIFT) ? 4'h1 : 4'h2)); // see RQ10
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tx_st_r <= TX_IDLE;
         tx_sh_r <= 11'h7FF;
         tx_left_r <= 4'h0;
         tx_tmr_r <= 16'h0000;
         m0_rx_r <= 1'b0;
         txd_r <= 1'b1;
      end else begin
         case (tx_st_r)
            TX_IDLE: begin
               tx_tmr_r <= period - 16'h0001;
               if (fifo_valid) begin
                  tx_st_r <= TX_RUN;
                  m0_rx_r <= 1'b0;
                  case (mode)
                     MODE_SHIFT: begin
                        tx_sh_r <= {3'h7, fifo_data};
                        tx_left_r <= M0_BITS;
                        txd_r <= 1'b0;
                     end
                     MODE_ASYNC8: begin
                        tx_sh_r <= {2'h3, fifo_data, 1'b0};
                        tx_left_r <= M1_BITS;
                        txd_r <= 1'b0;
                     end
                     default: begin
                        tx_sh_r <= {1'b1, tb8_r, fifo_data, 1'b0}; // see RQ8
                        tx_left_r <= M23_BITS;
                        txd_r <= 1'b0;
                     end
                  endcase
               end else if (m0_rx_start) begin
                  tx_st_r <= TX_RUN;
                  m0_rx_r <= 1'b1;
                  tx_sh_r <= 11'h7FF;
                  tx_left_r <= M0_BITS;
                  txd_r <= 1'b0;
               end
            end
            TX_RUN: begin
               if (mode == MODE_SHIFT && tx_tmr_r == {1'b0, period[15:1]}) begin
                  txd_r <= 1'b1;
                  if (m0_rx_r) begin
                     tx_sh_r <= {tx_sh_r[10:8], dat_s2_r, tx_sh_r[7:1]};
                  end
               end
               if (tx_end_bit) begin
                  tx_tmr_r <= period - 16'h0001;
                  tx_left_r <= tx_left_r - 4'h1;
                  if (!m0_rx_r) begin
                     tx_sh_r <= {1'b1, tx_sh_r[10:1]};
                  end
                  if (tx_left_r == 4'h1) begin
                     tx_st_r <= TX_IDLE;
                     txd_r <= 1'b1;
                  end else begin
                     txd_r <= (mode == MODE_SHIFT) ? 1'b0 : tx_sh_r[1];
                  end
               end else begin
                  tx_tmr_r <= tx_tmr_r - 16'h0001;
               end
            end
            default: tx_st_r <= TX_IDLE;
         endcase
      end
   end
   assign link.txd = txd_r;
   assign link.dat_dev_o = tx_sh_r[0];
   assign link.dat_dev_oe_n = !((tx_st_r == TX_RUN) && (mode == MODE_SHIFT) && !m0_rx_r);

   ////////////////////////////////////////////////////////////////////////////////
   // asynchronous receiver, samples mid bit
   rx_state_t rx_st_r;
   logic [15:0] rx_tmr_r;
   logic [3:0] rx_left_r;
   logic [8:0] rx_sh_r;
   logic rx_stop_pt, ninth_on, stop_ok, qualified;
   assign ninth_on = mode[1];
   assign rx_stop_pt = (rx_st_r == RX_DATA) && (rx_tmr_r == 16'h0000) && (rx_left_r == 4'h1);
   assign stop_ok = dat_s2_r;
   assign qualified = !mpq_r || (ninth_on ? rx_sh_r[8] : stop_ok); // see RQ4 see RQ5
   assign fe_set = rx_stop_pt && !stop_ok; // see RQ3
   assign rb8_set = rx_stop_pt && qualified;
   assign rb8_set_val = ninth_on ? rx_sh_r[8] : stop_ok; // see RQ9
   assign ri_set = (rx_stop_pt && qualified) || (m0_done && m0_rx_r); // see RQ11
   // the mode 0 marker outlives its frame
   assign rx_load = (m0_done && m0_rx_r) ? tx_sh_r[7:0] : (ninth_on ? rx_sh_r[7:0] : rx_sh_r[8:1]);
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rx_st_r <= RX_IDLE;
         rx_tmr_r <= 16'h0000;
         rx_left_r <= 4'h0;
         rx_sh_r <= 9'h000;
      end else begin
         case (rx_st_r)
            RX_IDLE: begin
               if (ren_r && mode != MODE_SHIFT && dat_prev_r && !dat_s2_r) begin // see RQ7 see RQ13
                  rx_st_r <= RX_START;
                  rx_tmr_r <= {1'b0, period[15:1]};
               end
            end
            RX_START: begin
               if (rx_tmr_r == 16'h0000) begin
                  rx_st_r <= dat_s2_r ? RX_IDLE : RX_DATA;
                  rx_tmr_r <= period - 16'h0001;
                  rx_left_r <= ninth_on ? M23_BITS - 4'h1 : M1_BITS - 4'h1;
               end else begin
                  rx_tmr_r <= rx_tmr_r - 16'h0001;
               end
            end
            RX_DATA: begin
               if (rx_tmr_r == 16'h0000) begin
                  rx_tmr_r <= period - 16'h0001;
                  rx_left_r <= rx_left_r - 4'h1;
                  if (rx_left_r == 4'h1) begin
                     rx_st_r <= RX_IDLE;
                  end else begin
                     rx_sh_r <= {dat_s2_r, rx_sh_r[8:1]};
                  end
               end else begin
                  rx_tmr_r <= rx_tmr_r - 16'h0001;
               end
            end
            default: rx_st_r <= RX_IDLE;
         endcase
      end
   end
endmodule // ser0_port
`default_nettype wire

// >>> rtl/ser0_pkg.sv
// constants, types and shared helpers of the serial port zero link
// Summary of operation
// RQ1: mode bits choose sync or async frame
// RQ2: view select makes bit 7 mode or error
// RQ3: bad stop bit sets error; software clears
// RQ4: modes 2/3 qualify: ninth zero, no done
// RQ5: mode 1 qualify: bad stop, no done
// RQ6: mode 0 qualify bit picks 12 or 4
// RQ7: receive only while receive enable set
// RQ8: ninth transmit bit sent in modes 2/3
// RQ9: ninth receive bit holds ninth or stop
// RQ10: transmit done at stop start or eighth
// RQ11: receive done mid stop or eighth bit
// RQ12: buffer reads receive, writes transmit
// RQ13: buffer write starts frame; start bit samples
`default_nettype none
package ser0_pkg;
   localparam logic [7:0] SERIAL_CTRL_ADDR = 8'h98;
   localparam logic [7:0] SERIAL_BUFFER_ADDR = 8'h99;
   localparam logic [7:0] POWER_CTRL_ADDR = 8'h87;
   localparam logic [7:0] SERIAL_CTRL_RESET = 8'h00;
   localparam logic [7:0] POWER_CTRL_RESET = 8'h00;
   // serial_ctrl_reg fields
   localparam int B_MODE_HI = 7;
   localparam int B_MODE_LO = 6;
   localparam int B_MPQ = 5;
   localparam int B_REN = 4;
   localparam int B_TB8 = 3;
   localparam int B_RB8 = 2;
   localparam int B_TI = 1;
   localparam int B_RI = 0;
   // power_ctrl_reg fields
   localparam int B_DOUBLE_RATE = 7;
   localparam int B_FRAME_VIEW = 6;
   // bit periods in oscillator cycles
   localparam logic [15:0] M0_SLOW_CYCLES = 16'h000C;
   localparam logic [15:0] M0_FAST_CYCLES = 16'h0004;
   localparam logic [15:0] M2_SLOW_CYCLES = 16'h0040;
   localparam logic [15:0] M2_FAST_CYCLES = 16'h0020;
   localparam logic [3:0] M0_BITS = 4'h8;
   localparam logic [3:0] M1_BITS = 4'hA;
   localparam logic [3:0] M23_BITS = 4'hB;
   localparam int FIFO_DEPTH = 16;
   typedef enum logic [1:0] {MODE_SHIFT, MODE_ASYNC8, MODE_FIXED9, MODE_VAR9} mode_t;
   typedef enum {TX_IDLE, TX_RUN} tx_state_t;
   typedef enum {RX_IDLE, RX_START, RX_DATA} rx_state_t;

   // cycles of one bit time for the selected mode
   function automatic logic [15:0] bit_cycles(input mode_t m, input logic mpq, input logic dbl,
                                              input logic [15:0] var_cyc);
      case (m)
         MODE_SHIFT: bit_cycles = mpq ? M0_FAST_CYCLES : M0_SLOW_CYCLES;
         MODE_FIXED9: bit_cycles = dbl ? M2_FAST_CYCLES : M2_SLOW_CYCLES;
         default: bit_cycles = var_cyc;
      endcase
   endfunction
endpackage
`default_nettype wire

// >>> rtl/ser0_link_if.sv
// link wires between the port and the remote node
`timescale 1ns/1ns
`default_nettype none
interface ser0_link_if;
   logic txd;
   logic dat_dev_o;
   logic dat_dev_oe_n;
   logic dat_node_o;
   logic dat_node_oe_n;
   logic dat_line;
   // device wins a clash; an undriven line floats high
   assign dat_line = !dat_dev_oe_n ? dat_dev_o : (!dat_node_oe_n ? dat_node_o : 1'b1);
   modport dev (output txd, output dat_dev_o, output dat_dev_oe_n, input dat_line);
   modport node (input txd, output dat_node_o, output dat_node_oe_n, input dat_line);
endinterface
`default_nettype wire

// >>> rtl/ser0_node.sv
// remote serial node: the far end of serial port zero
`timescale 1ns/1ns
`default_nettype none
module ser0_node (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // configuration
   input wire ser0_pkg::mode_t cfg_mode,
   input wire logic [15:0] cfg_bit_cycles,
   // words to send: ninth bit on top
   input wire logic [8:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   // words received
   output logic [8:0] rx_data,
   output logic rx_valid,
   output logic rx_stop_ok,
   // link
   ser0_link_if.node link
);
   import ser0_pkg::*;

   logic clk_s1_r, clk_s2_r, clk_prev_r, dat_s1_r, dat_s2_r;
   logic rise, fall, async;
   assign async = (cfg_mode != MODE_SHIFT);
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         {clk_s1_r, clk_s2_r, clk_prev_r, dat_s1_r, dat_s2_r} <= 5'h1F;
      end else begin
         clk_s1_r <= link.txd;
         clk_s2_r <= clk_s1_r;
         clk_prev_r <= clk_s2_r;
         dat_s1_r <= link.dat_line;
         dat_s2_r <= dat_s1_r;
      end
   end
   assign rise = clk_s2_r && !clk_prev_r;
   assign fall = !clk_s2_r && clk_prev_r;

   ////////////////////////////////////////////////////////////////////////////////
   // sender: async frames on the data line, or mode 0 bits shifted on the clock
   logic [10:0] tx_sh_r;
   logic [3:0] tx_left_r;
   logic [15:0] tx_tmr_r;
   logic tx_busy_r;
   assign tx_ready = !tx_busy_r;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tx_sh_r <= 11'h7FF;
         tx_left_r <= 4'h0;
         tx_tmr_r <= 16'h0000;
         tx_busy_r <= 1'b0;
      end else if (!tx_busy_r) begin
         tx_tmr_r <= cfg_bit_cycles - 16'h0001;
         if (tx_valid) begin
            tx_busy_r <= 1'b1;
            case (cfg_mode)
               MODE_SHIFT: begin
                  tx_sh_r <= {3'h7, tx_data[7:0]};
                  tx_left_r <= M0_BITS;
               end
               MODE_ASYNC8: begin
                  tx_sh_r <= {2'h3, tx_data[7:0], 1'b0};
                  tx_left_r <= M1_BITS;
               end
               default: begin
                  tx_sh_r <= {1'b1, tx_data, 1'b0}; // see RQ8
                  tx_left_r <= M23_BITS;
               end
            endcase
         end
      end else if (async ? (tx_tmr_r == 16'h0000) : rise) begin
         tx_tmr_r <= cfg_bit_cycles - 16'h0001;
         tx_left_r <= tx_left_r - 4'h1;
         if (!async) begin
            tx_sh_r <= {1'b1, tx_sh_r[10:1]};
         end else if (tx_left_r != 4'h1) begin
            tx_sh_r <= {1'b1, tx_sh_r[10:1]};
         end
         if (tx_left_r == 4'h1) begin
            tx_busy_r <= 1'b0;
         end
      end else if (async) begin
         tx_tmr_r <= tx_tmr_r - 16'h0001;
      end
   end
   // in mode 0 the next bit goes out after the device samples on the rising clock
   assign link.dat_node_o = tx_sh_r[0];
   assign link.dat_node_oe_n = !(async || tx_busy_r);

   ////////////////////////////////////////////////////////////////////////////////
   // receiver: async frames on the clock wire, or mode 0 bits on the data line
   rx_state_t rx_st_r;
   logic [15:0] rx_tmr_r;
   logic [3:0] rx_left_r;
   logic [9:0] rx_sh_r;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rx_st_r <= RX_IDLE;
         rx_tmr_r <= 16'h0000;
         rx_left_r <= 4'h0;
         rx_sh_r <= 10'h000;
         rx_data <= 9'h000;
         rx_valid <= 1'b0;
         rx_stop_ok <= 1'b0;
      end else begin
         rx_valid <= 1'b0;
         case (rx_st_r)
            RX_IDLE: begin
               rx_left_r <= async ? ((cfg_mode == MODE_ASYNC8) ? M1_BITS : M23_BITS) - 4'h1 : M0_BITS;
               rx_tmr_r <= {1'b0, cfg_bit_cycles[15:1]};
               if (async && fall) begin
                  rx_st_r <= RX_START;
               end else if (!async && fall) begin
                  rx_st_r <= RX_DATA;
               end
            end
            RX_START: begin
               if (rx_tmr_r == 16'h0000) begin
                  rx_st_r <= clk_s2_r ? RX_IDLE : RX_DATA;
                  rx_tmr_r <= cfg_bit_cycles - 16'h0001;
               end else begin
                  rx_tmr_r <= rx_tmr_r - 16'h0001;
               end
            end
            RX_DATA: begin
               if (async ? (rx_tmr_r == 16'h0000) : rise) begin
                  rx_tmr_r <= cfg_bit_cycles - 16'h0001;
                  rx_left_r <= rx_left_r - 4'h1;
                  rx_sh_r <= {async ? clk_s2_r : dat_s2_r, rx_sh_r[9:1]};
                  if (rx_left_r == 4'h1) begin
                     rx_st_r <= RX_IDLE;
                     rx_valid <= 1'b1;
                     rx_stop_ok <= async ? clk_s2_r : 1'b1;
                     case (cfg_mode)
                        MODE_SHIFT: rx_data <= {1'b0, dat_s2_r, rx_sh_r[9:3]};
                        MODE_ASYNC8: rx_data <= {1'b0, rx_sh_r[9:2]};
                        default: rx_data <= rx_sh_r[9:1];
                     endcase
                  end
               end else if (async) begin
                  rx_tmr_r <= rx_tmr_r - 16'h0001;
               end
            end
            default: rx_st_r <= RX_IDLE;
         endcase
      end
   end
endmodule // ser0_node
`default_nettype wire

// >>> dv/ser0_chk.sv
// link checker of serial port zero
`timescale 1ns/1ns
`default_nettype none
module ser0_chk (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // link wires
   input wire logic txd,
   input wire logic dat_dev_o,
   input wire logic dat_dev_oe_n,
   input wire logic dat_node_oe_n,
   input wire logic dat_line
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   property p_no_clash; !(!dat_dev_oe_n && !dat_node_oe_n); endproperty
   a_no_clash: assert property (p_no_clash) else $error("both ends drive data");
   property p_drive_start; $fell(dat_dev_oe_n) |-> !txd; endproperty
   a_drive_start: assert property (p_drive_start) else $error("drive began with clock high");
   property p_low_min; $fell(txd) |=> !txd; endproperty
   a_low_min: assert property (p_low_min) else $error("txd low too short");
   property p_high_min; $rose(txd) |=> txd; endproperty
   a_high_min: assert property (p_high_min) else $error("txd high too short");
   // longest legal low run is a start bit plus nine zero bits
   property p_low_max; $fell(txd) |-> ##[1:700] txd; endproperty
   a_low_max: assert property (p_low_max) else $error("txd stuck low");
   property p_dat_stable; (!dat_dev_oe_n && !$past(dat_dev_oe_n) && txd && $past(txd)) |-> $stable(dat_dev_o);
   endproperty
   a_dat_stable: assert property (p_dat_stable) else $error("data moved in clock high");
   property p_drive_len; $fell(dat_dev_oe_n) |-> !dat_dev_oe_n [*8]; endproperty
   a_drive_len: assert property (p_drive_len) else $error("shift drive too short");
   property p_release; $rose(dat_dev_oe_n) |-> txd; endproperty
   a_release: assert property (p_release) else $error("drive released mid bit");
endmodule // ser0_chk
`default_nettype wire

// >>> dv/tb_top.sv
// self-checking bench for the serial port zero link
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import ser0_pkg::*;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] sfr_addr = 8'h00;
   logic [7:0] sfr_wdata = 8'h00;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic [7:0] sfr_rdata;
   logic sfr_wr_ready;
   logic wr_ok;
   logic [15:0] var_cyc = 16'h0010;
   mode_t nmode = MODE_ASYNC8;
   logic [8:0] ntx_data = 9'h000;
   logic ntx_valid = 1'b0;
   logic ntx_ready;
   logic [8:0] nrx_data;
   logic nrx_valid;
   logic nrx_stop;
   logic [8:0] nrx_last = 9'h000;
   logic nrx_stop_l = 1'b0;
   int nrx_cnt = 0;
   logic txd_q = 1'b1;
   int gap = 0;
   int fall_gap = 0;
   int cyc = 0;
   int miscompares = 0;
   int check_count = 0;
   ser0_link_if i_ser0_link_if();
   ser0_port i_ser0_port(.core_clk(core_clk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_wr_ready(sfr_wr_ready), .var_bit_cycles(var_cyc),
      .link(i_ser0_link_if));
   ser0_node i_ser0_node(.core_clk(core_clk), .rstn(rstn), .cfg_mode(nmode), .cfg_bit_cycles(var_cyc),
      .tx_data(ntx_data), .tx_valid(ntx_valid), .tx_ready(ntx_ready), .rx_data(nrx_data), .rx_valid(nrx_valid),
      .rx_stop_ok(nrx_stop), .link(i_ser0_link_if));
   ser0_chk i_ser0_chk(.core_clk(core_clk), .rstn(rstn), .txd(i_ser0_link_if.txd),
      .dat_dev_o(i_ser0_link_if.dat_dev_o), .dat_dev_oe_n(i_ser0_link_if.dat_dev_oe_n),
      .dat_node_oe_n(i_ser0_link_if.dat_node_oe_n), .dat_line(i_ser0_link_if.dat_line));
   always #4 core_clk = !core_clk;
   // shift clock period is measured between falling edges of txd
   always @(posedge core_clk) begin
      txd_q <= i_ser0_link_if.txd;
      gap <= (txd_q && !i_ser0_link_if.txd) ? 1 : gap + 1;
      if (txd_q && !i_ser0_link_if.txd) fall_gap <= gap;
      if (nrx_valid === 1'b1) begin
         nrx_cnt <= nrx_cnt + 1;
         nrx_last <= nrx_data;
         nrx_stop_l <= nrx_stop;
      end
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         $display("ERROR t=%0t timeout", $time);
         miscompares++;
         report_and_stop();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [8:0] g, input logic [8:0] e);
      check_count++;
      if (g !== e) begin
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
         miscompares++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge core_clk);
      sfr_addr <= a;
      sfr_wdata <= v;
      sfr_wr <= 1'b1;
      #1 wr_ok = sfr_wr_ready;
      @(posedge core_clk);
      sfr_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge core_clk);
      sfr_rd <= 1'b0;
      #1 d = sfr_rdata;
   endtask
   task automatic wait_flag(input int b);
      logic [7:0] d;
      int n;
      n = 0;
      do begin
         rd(SERIAL_CTRL_ADDR, d);
         n++;
      end while (d[b] !== 1'b1 && n < 600);
      chk(9'(d[b]), 9'h001);
   endtask
   task automatic wait_nrx(input int t);
      int n;
      n = 0;
      while (nrx_cnt < t && n < 4000) begin
         @(posedge core_clk);
         n++;
      end
      chk(9'(nrx_cnt), 9'(t));
   endtask
   task automatic nsend(input logic [8:0] w);
      @(posedge core_clk);
      ntx_data <= w;
      ntx_valid <= 1'b1;
      #1;
      while (ntx_ready !== 1'b1) @(posedge core_clk) #1;
      @(posedge core_clk);
      ntx_valid <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] d;
      int acc;
      repeat (10) @(posedge core_clk);
      rstn <= 1'b1;
      rd(SERIAL_CTRL_ADDR, d);
      chk(9'(d), 9'(SERIAL_CTRL_RESET));
      rd(POWER_CTRL_ADDR, d);
      chk(9'(d), 9'(POWER_CTRL_RESET));
      wr(8'h55, 8'hFF);
      rd(8'h55, d);
      chk(9'(d), 9'h000);
      // bit 7 holds two separate fields behind the view select
      wr(POWER_CTRL_ADDR, 8'h40);
      wr(SERIAL_CTRL_ADDR, 8'h80);
      rd(SERIAL_CTRL_ADDR, d);
      chk(9'(d), 9'h080);
      wr(POWER_CTRL_ADDR, 8'h00);
      rd(SERIAL_CTRL_ADDR, d);
      chk(9'(d), 9'h000);
      $display("test regs done");
      wr(SERIAL_CTRL_ADDR, 8'h50);
      wr(SERIAL_BUFFER_ADDR, 8'hA5);
      wait_nrx(1);
      chk(nrx_last, 9'h0A5);
      chk(9'(nrx_stop_l), 9'h001);
      wait_flag(B_TI);
      nsend(9'h03C);
      wait_flag(B_RI);
      rd(SERIAL_BUFFER_ADDR, d);
      chk(9'(d), 9'h03C);
      rd(SERIAL_CTRL_ADDR, d);
      chk(9'(d[B_RB8]), 9'h001);
      wr(SERIAL_CTRL_ADDR, 8'h40);
      nsend(9'h066);
      repeat (220) @(posedge core_clk);
      rd(SERIAL_CTRL_ADDR, d);
      chk(9'(d[B_RI]), 9'h000);
      $display("test mode1 done");
      nmode <= MODE_VAR9;
      wr(SERIAL_CTRL_ADDR, 8'hF8);
      wr(SERIAL_BUFFER_ADDR, 8'h5A);
      wait_nrx(2);
      chk(nrx_last, 9'h15A);
      nsend(9'h011);
      repeat (220) @(posedge core_clk);
      rd(SERIAL_CTRL_ADDR, d);
      chk(9'(d[B_RI]), 9'h000);
      nsend(9'h122);
      wait_flag(B_RI);
      rd(SERIAL_BUFFER_ADDR, d);
      chk(9'(d), 9'h022);
      // ninth bit 0 sits on the mode 1 stop sample
      wr(SERIAL_CTRL_ADDR, 8'h70);
      wr(POWER_CTRL_ADDR, 8'h40);
      nsend(9'h0AB);
      repeat (220) @(posedge core_clk);
      rd(SERIAL_CTRL_ADDR, d);
      chk(9'(d), 9'h0F0);
      $display("test mode3 done");
      nmode <= MODE_SHIFT;
      for (int i = 0; i < 2; i++) begin
         wr(SERIAL_CTRL_ADDR, i ? 8'h20 : 8'h00);
         wr(SERIAL_BUFFER_ADDR, 8'hC3 ^ 8'(i));
         wait_nrx(3 + i);
         chk(nrx_last[7:0], 9'h0C3 ^ 9'(i));
         chk(9'(fall_gap), i ? 9'h004 : 9'h00C);
         wait_flag(B_TI);
      end
      nsend(9'h05C);
      wr(SERIAL_CTRL_ADDR, 8'h10);
      wait_flag(B_RI);
      rd(SERIAL_BUFFER_ADDR, d);
      chk(9'(d), 9'h05C);
      $display("test mode0 done");
      // the transmitter holds one word beyond the sixteen queued
      nmode <= MODE_ASYNC8;
      wr(SERIAL_CTRL_ADDR, 8'h40);
      acc = 0;
      for (int i = 0; i < 20; i++) begin
         wr(SERIAL_BUFFER_ADDR, 8'h80 + 8'(i));
         if (wr_ok === 1'b1) acc++;
      end
      chk(9'(acc), 9'h011);
      wait_nrx(22);
      chk(nrx_last, 9'h090);
      $display("test fifo done");
      report_and_stop();
   end
endmodule // tb_top
`default_nettype wire
